// [mmc_map.svh]
// register offsets, field positions, reset values and frame timing of the management controller
`ifndef MMC_MAP_SVH
`define MMC_MAP_SVH

`define MMC_ADDR_W 8
`define MMC_DATA_W 8

`define MMC_OFS_CONTROL 8'h3B
`define MMC_OFS_WDATA_LO 8'h3C
`define MMC_OFS_WDATA_HI 8'h3D
`define MMC_OFS_PHY_ADDR 8'h3E
`define MMC_OFS_REG_SEL 8'h3F
`define MMC_OFS_RDATA_LO 8'h40
`define MMC_OFS_RDATA_HI 8'h41
`define MMC_OFS_STATUS 8'h42
`define MMC_OFS_INT_STAT 8'h43

`define MMC_CTL_RESET 8'h00
`define MMC_BIT_WR_TRIG 7
`define MMC_BIT_RD_TRIG 6
`define MMC_BIT_STEP 5
`define MMC_BIT_SCAN 4
`define MMC_BIT_SKIP 3
`define MMC_DIV_MSB 2
`define MMC_BIT_BUSY 7
`define MMC_BIT_DONE 0

`define MMC_PREAMBLE 32'hFFFFFFFF
`define MMC_START 2'h1
`define MMC_OPC_WR 2'h1
`define MMC_OPC_RD 2'h2
`define MMC_TA_WR 2'h2
`define MMC_TA_RD 2'h3
`define MMC_PRE_BITS 6'h20
`define MMC_TA_POS 6'h2E
`define MMC_DATA_POS 6'h30
`define MMC_LAST_POS 6'h3F
`define MMC_LAST_ADDR 5'h1F

`define MMC_DIV_0 5'h04
`define MMC_DIV_1 5'h04
`define MMC_DIV_2 5'h06
`define MMC_DIV_3 5'h08
`define MMC_DIV_4 5'h0A
`define MMC_DIV_5 5'h0E
`define MMC_DIV_6 5'h14
`define MMC_DIV_7 5'h1C

`endif

// [mmc_pkg.sv]
// types shared by the management controller modules
package mmc_pkg;
  typedef enum logic [1:0] {
    MMC_IDLE = 2'b00,
    MMC_WAIT = 2'b01,
    MMC_RUN = 2'b10
  } mmc_state_type;
  typedef enum logic [1:0] {
    MMC_OP_WRITE = 2'b00,
    MMC_OP_READ = 2'b01,
    MMC_OP_SCAN = 2'b10
  } mmc_op_type;
endpackage

// [mmc_tick_if.sv]
// divisor select and management clock edge strobes between engine and divider
`timescale 1ns/1ps
interface mmc_tick_if;
  logic [2:0] divisor;
  logic rise;
  logic fall;
  modport gen (input divisor, output rise, output fall);
  modport eng (output divisor, input rise, input fall);
endinterface

// [mmc_clock_divider.sv]
// management clock divider with edge strobes
`timescale 1ns/1ps
`include "mmc_map.svh"
module mmc_clock_divider (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // strobes to the engine
  mmc_tick_if.gen tick,
  // management clock pin
  output logic mdc
);
  import mmc_pkg::*;

  logic [4:0] div;
  logic [3:0] half_last;
  logic [3:0] cnt;
  logic wrap;

  always_comb begin
    case (tick.divisor)
      3'h0: div = `MMC_DIV_0;
      3'h1: div = `MMC_DIV_1;
      3'h2: div = `MMC_DIV_2;
      3'h3: div = `MMC_DIV_3;
      3'h4: div = `MMC_DIV_4;
      3'h5: div = `MMC_DIV_5;
      3'h6: div = `MMC_DIV_6;
      default: div = `MMC_DIV_7;
    endcase
  end

  // half period minus one, in system clocks
  assign half_last = div[4:1] - 4'h1;
  assign wrap = (cnt >= half_last);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 4'h0;
      mdc <= 1'b0;
    end else if (ce) begin
      cnt <= wrap ? 4'h0 : cnt + 4'h1;
      if (wrap) begin
        mdc <= ~mdc;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tick.rise <= 1'b0;
      tick.fall <= 1'b0;
    end else if (ce) begin
      tick.rise <= wrap & ~mdc;
      tick.fall <= wrap & mdc;
    end
  end

  // a new divisor code may find the count above its half period; the next enabled edge wraps it
  a_half_bound: assert property (@(posedge mclk) disable iff (!rstn)
    ($past(ce) && $stable(tick.divisor)) |-> cnt <= half_last)
    else $error("divider count passed half period");
endmodule

// [mmc_controller.sv]
// management serial controller: registers, frame engine and scan sequencing
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "mmc_map.svh"
module mmc_controller (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // register port
  input wire logic [`MMC_ADDR_W-1:0] addr,
  input wire logic [`MMC_DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [`MMC_DATA_W-1:0] rdata,
  // management pins
  output logic mdc,
  input wire logic mdio_in,
  output logic mgmt_serial_out,
  output logic mdio_oe
);
  import mmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] mgmt_control_reg;
  logic [7:0] phy_write_data_low;
  logic [7:0] phy_write_data_high;
  logic [4:0] phy_address_reg;
  logic [4:0] phy_register_select;
  logic [15:0] phy_read_data;
  logic [4:0] status_addr;
  logic mgmt_done_flag;

  mmc_state_type state;
  mmc_op_type op;
  logic [5:0] cnt;
  logic [63:0] frame;
  logic [15:0] phy_read_bus;
  logic [4:0] target;
  logic [4:0] scan_addr;
  logic [4:0] frame_addr;
  logic fin;
  logic busy;
  logic go;
  mmc_op_type next_op;
  logic [15:0] phy_write_data;
  logic [31:0] header;
  logic [5:0] next_cnt;

  assign busy = (state != MMC_IDLE);
  assign phy_write_data = {phy_write_data_high, phy_write_data_low};
  assign next_cnt = cnt + 6'h01;

  wire write_ctl = wr && (addr == `MMC_OFS_CONTROL);
  wire wr_pend = mgmt_control_reg[`MMC_BIT_WR_TRIG];
  wire rd_pend = mgmt_control_reg[`MMC_BIT_RD_TRIG];
  wire scan_on = mgmt_control_reg[`MMC_BIT_SCAN];
  wire step_on = mgmt_control_reg[`MMC_BIT_STEP];

  // control register; trigger bits only latch on a rising edge while idle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mgmt_control_reg <= `MMC_CTL_RESET;
    end else if (ce) begin
      if (write_ctl) begin
        mgmt_control_reg[5:0] <= wdata[5:0];
        if (!busy && !wr_pend) begin
          mgmt_control_reg[`MMC_BIT_WR_TRIG] <= wdata[`MMC_BIT_WR_TRIG];
        end
        if (!busy && !rd_pend) begin
          mgmt_control_reg[`MMC_BIT_RD_TRIG] <= wdata[`MMC_BIT_RD_TRIG];
        end
      end
      if (fin && op == MMC_OP_WRITE) begin
        mgmt_control_reg[`MMC_BIT_WR_TRIG] <= 1'b0;
      end
      if (fin && op == MMC_OP_READ) begin
        mgmt_control_reg[`MMC_BIT_RD_TRIG] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phy_write_data_low <= 8'h00;
      phy_write_data_high <= 8'h00;
      phy_address_reg <= 5'h00;
      phy_register_select <= 5'h00;
    end else if (ce && wr) begin
      case (addr)
        `MMC_OFS_WDATA_LO: phy_write_data_low <= wdata;
        `MMC_OFS_WDATA_HI: phy_write_data_high <= wdata;
        `MMC_OFS_PHY_ADDR: phy_address_reg <= wdata[4:0];
        `MMC_OFS_REG_SEL: phy_register_select <= wdata[4:0];
        default: ;
      endcase
    end
  end

  // done flag: write one clears, a completion in the same cycle wins
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mgmt_done_flag <= 1'b0;
    end else if (ce) begin
      if (fin) begin
        mgmt_done_flag <= 1'b1;
      end else if (wr && addr == `MMC_OFS_INT_STAT && wdata[`MMC_BIT_DONE]) begin
        mgmt_done_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= 8'h00;
      if (rd) begin
        case (addr)
          `MMC_OFS_CONTROL: rdata <= mgmt_control_reg;
          `MMC_OFS_WDATA_LO: rdata <= phy_write_data_low;
          `MMC_OFS_WDATA_HI: rdata <= phy_write_data_high;
          `MMC_OFS_PHY_ADDR: rdata <= {3'h0, phy_address_reg};
          `MMC_OFS_REG_SEL: rdata <= {3'h0, phy_register_select};
          `MMC_OFS_RDATA_LO: rdata <= phy_read_data[7:0];
          `MMC_OFS_RDATA_HI: rdata <= phy_read_data[15:8];
          `MMC_OFS_STATUS: rdata <= {busy, 2'h0, status_addr};
          `MMC_OFS_INT_STAT: rdata <= {7'h00, mgmt_done_flag};
          default: rdata <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // clock divider

  mmc_tick_if tick ();
  assign tick.divisor = mgmt_control_reg[`MMC_DIV_MSB:0];

  mmc_clock_divider u_div (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .tick(tick),
    .mdc(mdc)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // frame engine

  // triggered operations take priority over scanning
  // the completion cycle still shows the old trigger and scan address, so nothing starts there
  always_comb begin
    go = !busy && !fin && (wr_pend || rd_pend || scan_on);
    if (wr_pend) begin
      next_op = MMC_OP_WRITE;
    end else if (rd_pend) begin
      next_op = MMC_OP_READ;
    end else begin
      next_op = MMC_OP_SCAN;
    end
  end

  always_comb begin
    target = (next_op == MMC_OP_SCAN) ? scan_addr : phy_address_reg;
    if (next_op == MMC_OP_WRITE) begin
      header = {`MMC_START, `MMC_OPC_WR, target, phy_register_select, `MMC_TA_WR, phy_write_data};
    end else begin
      header = {`MMC_START, `MMC_OPC_RD, target, phy_register_select, `MMC_TA_RD, 16'hFFFF};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= MMC_IDLE;
      op <= MMC_OP_WRITE;
      cnt <= 6'h00;
      frame <= 64'h0000000000000000;
      status_addr <= 5'h00;
      frame_addr <= 5'h00;
      mgmt_serial_out <= 1'b0;
      mdio_oe <= 1'b0;
      fin <= 1'b0;
    end else if (ce) begin
      fin <= 1'b0;
      case (state)
        MMC_IDLE: begin
          if (go) begin
            op <= next_op;
            frame_addr <= target;
            state <= MMC_WAIT;
            if (mgmt_control_reg[`MMC_BIT_SKIP]) begin
              frame <= {header, 32'h00000000};
              cnt <= `MMC_PRE_BITS;
            end else begin
              frame <= {`MMC_PREAMBLE, header};
              cnt <= 6'h00;
            end
          end
        end
        MMC_WAIT: begin
          if (tick.fall) begin
            mgmt_serial_out <= frame[63];
            mdio_oe <= 1'b1;
            state <= MMC_RUN;
          end
        end
        MMC_RUN: begin
          if (tick.fall) begin
            if (cnt == `MMC_LAST_POS) begin
              mgmt_serial_out <= 1'b0;
              mdio_oe <= 1'b0;
              fin <= 1'b1;
              // status moves only at completion, so it names the source of the data just read
              status_addr <= frame_addr;
              state <= MMC_IDLE;
            end else begin
              cnt <= next_cnt;
              frame <= {frame[62:0], 1'b0};
              mgmt_serial_out <= frame[62];
              mdio_oe <= !(op != MMC_OP_WRITE && next_cnt >= `MMC_TA_POS);
            end
          end
        end
        default: state <= MMC_IDLE;
      endcase
    end
  end

  // read bits sampled on the rising management clock edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phy_read_bus <= 16'h0000;
    end else if (ce && state == MMC_RUN && tick.rise && op != MMC_OP_WRITE && cnt >= `MMC_DATA_POS) begin
      phy_read_bus <= {phy_read_bus[14:0], mdio_in};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phy_read_data <= 16'h0000;
    end else if (ce && fin && op != MMC_OP_WRITE) begin
      phy_read_data <= phy_read_bus;
    end
  end

  // scan address follows the programmed address until a stepping scan moves it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scan_addr <= 5'h00;
    end else if (ce) begin
      if (!scan_on) begin
        scan_addr <= phy_address_reg;
      end else if (fin && op == MMC_OP_SCAN) begin
        if (step_on && scan_addr != `MMC_LAST_ADDR) begin
          scan_addr <= scan_addr + 5'h01;
        end else begin
          scan_addr <= phy_address_reg;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  a_write_selfclr: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && fin && op == MMC_OP_WRITE) |=> !mgmt_control_reg[`MMC_BIT_WR_TRIG])
    else $error("write trigger did not clear after frame");

  a_busy_ignore: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && busy && !fin && write_ctl && !wr_pend) |=> !mgmt_control_reg[`MMC_BIT_WR_TRIG])
    else $error("trigger accepted while busy");

  a_scan_done: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && fin && op == MMC_OP_SCAN) |=> mgmt_done_flag)
    else $error("done flag not set after scan read");

  a_scan_data: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && fin && op == MMC_OP_SCAN) |=> (phy_read_data == $past(phy_read_bus) && status_addr == $past(frame_addr)))
    else $error("scan result not captured");

  a_read_capture: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && fin && op == MMC_OP_READ) |=> phy_read_data == $past(phy_read_bus))
    else $error("read data not captured");

  // a finished trigger must not send its frame a second time
  a_one_frame: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && fin) |=> state == MMC_IDLE)
    else $error("frame restarted in completion cycle");

  a_target_addr: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && go && next_op != MMC_OP_SCAN) |=> frame_addr == $past(phy_address_reg))
    else $error("triggered frame not sent to programmed address");

  a_scan_wrap: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && scan_on && step_on && fin && op == MMC_OP_SCAN && scan_addr == `MMC_LAST_ADDR)
    |=> scan_addr == $past(phy_address_reg))
    else $error("scan did not wrap to programmed address");

  a_scan_step: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && scan_on && step_on && fin && op == MMC_OP_SCAN && scan_addr != `MMC_LAST_ADDR)
    |=> scan_addr == $past(scan_addr) + 5'h01)
    else $error("scan address did not advance");

  a_skip_start: assert property (@(posedge mclk) disable iff (!rstn)
    (ce && go && mgmt_control_reg[`MMC_BIT_SKIP]) |=> (cnt == `MMC_PRE_BITS && state == MMC_WAIT))
    else $error("preamble not skipped");

  a_read_release: assert property (@(posedge mclk) disable iff (!rstn)
    (state == MMC_RUN && op != MMC_OP_WRITE && cnt >= `MMC_TA_POS) |-> !mdio_oe)
    else $error("pin driven during read turnaround or data");

  a_write_msb: assert property (@(posedge mclk) disable iff (!rstn)
    (state == MMC_RUN && op == MMC_OP_WRITE && $changed(cnt) && cnt == `MMC_DATA_POS)
    |-> mgmt_serial_out == phy_write_data[15])
    else $error("write data msb not first");
endmodule

// [mmc_phy_model.sv]
// behavioural PHY on the management pins: decodes frames and answers reads
`timescale 1ns/1ps
module mmc_phy_model (
  // management pins
  input wire logic mdc,
  input wire logic mdio,
  input wire logic mac_oe,
  // read answer and pin drive
  input wire logic [15:0] reply_base,
  output logic phy_out,
  output logic phy_oe,
  // last decoded frame
  output logic [1:0] f_op,
  output logic [4:0] f_phy,
  output logic [4:0] f_reg,
  output logic [1:0] f_ta,
  output logic [15:0] f_data,
  output logic [7:0] f_pre,
  output logic f_clash,
  output int f_count
);
  logic [31:0] sh;
  logic [15:0] reply;
  logic rd_frame;
  int cnt;
  int ones;
  initial begin
    {phy_out, phy_oe, f_clash, rd_frame} = 4'h8;
    sh = 32'h00000000;
    cnt = 0;
    ones = 0;
    f_count = 0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // bits are taken on the rising management clock edge
  always @(posedge mdc) begin
    if (cnt == 0) begin
      if (mac_oe && mdio) ones = ones + 1;
      else if (mac_oe) begin
        cnt = 1;
        f_pre = ones[7:0];
      end else ones = 0;
    end else begin
      sh = {sh[30:0], mdio};
      cnt = cnt + 1;
      if (cnt == 4) rd_frame = (sh[1:0] == 2'h2);
      if (cnt == 9) reply = reply_base ^ {11'h000, sh[4:0]};
      // the controller must have let go of the line from the turnaround on
      if (rd_frame && cnt > 14 && mac_oe) f_clash = 1'b1;
      if (cnt == 32) begin
        {f_op, f_phy, f_reg, f_ta, f_data} = sh[29:0];
        f_count = f_count + 1;
        cnt = 0;
        ones = 0;
        rd_frame = 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // read answer: turnaround low, then data msb first, changed after the falling edge
  always @(negedge mdc) begin
    phy_oe = rd_frame && cnt > 14 && cnt < 32;
    phy_out = (cnt == 15) ? 1'b0 : reply[(31 - cnt) & 15];
  end
endmodule

// [mii_management_controller_tb_top.sv]
// self-checking bench for the management controller against a PHY model
`timescale 1ns/1ps
`include "mmc_map.svh"
module mii_management_controller_tb_top;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic mdc, mac_out, mdio_oe, phy_out, phy_oe, f_clash;
  logic [15:0] reply_base = 16'h0000;
  logic [1:0] f_op, f_ta;
  logic [4:0] f_phy, f_reg;
  logic [15:0] f_data;
  logic [7:0] f_pre;
  int f_count;
  int fail_count = 0;
  int total_checks = 0;
  int period = 0;
  time last_rise = 0;
  // pulled-up line: high when nobody drives it
  wire mdio = mdio_oe ? mac_out : (phy_oe ? phy_out : 1'b1);
  mmc_controller i_mmc_controller (.mclk(mclk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .mdc(mdc), .mdio_in(mdio), .mgmt_serial_out(mac_out), .mdio_oe(mdio_oe));
  mmc_phy_model i_mmc_phy_model (.mdc(mdc), .mdio(mdio), .mac_oe(mdio_oe), .reply_base(reply_base),
    .phy_out(phy_out), .phy_oe(phy_oe), .f_op(f_op), .f_phy(f_phy), .f_reg(f_reg), .f_ta(f_ta),
    .f_data(f_data), .f_pre(f_pre), .f_clash(f_clash), .f_count(f_count));
  always #25 mclk = ~mclk;
  always @(posedge mdc) begin
    period = int'(($time - last_rise) / 50);
    last_rise = $time;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_bit(input logic [7:0] a, input int b, input logic val);
    logic [7:0] v;
    int i;
    v = ~{8{val}};
    for (i = 0; i < 5000 && v[b] !== val; i++) reg_rd(a, v);
    if (v[b] !== val) begin
      fail_count++;
      $display("wait on register %h timed out", a);
      end_of_test;
    end
  endtask
  function automatic int div_of(input logic [2:0] c);
    int t[8] = '{4, 4, 6, 8, 10, 14, 20, 28};
    return t[c];
  endfunction
  // five scan frames at divisor 28 without preamble
  task automatic scan_run(input logic [4:0] start, input logic step);
    logic [7:0] v, lo, hi;
    logic [4:0] e;
    int i;
    e = start;
    reply_base = 16'($urandom);
    reg_wr(`MMC_OFS_PHY_ADDR, {3'h0, start});
    reg_wr(`MMC_OFS_CONTROL, {2'h0, step, 5'h1F});
    for (i = 0; i < 5; i++) begin
      wait_bit(`MMC_OFS_INT_STAT, 0, 1'b1);
      reg_rd(`MMC_OFS_STATUS, v);
      reg_rd(`MMC_OFS_RDATA_LO, lo);
      reg_rd(`MMC_OFS_RDATA_HI, hi);
      check(16'(v[4:0]), 16'(e));
      check({hi, lo}, reply_base ^ 16'(e));
      check(16'(f_phy), 16'(e));
      reg_wr(`MMC_OFS_INT_STAT, 8'h01);
      e = step ? ((e == `MMC_LAST_ADDR) ? start : e + 5'h01) : e;
    end
    reg_wr(`MMC_OFS_CONTROL, 8'h0F);
    wait_bit(`MMC_OFS_STATUS, 7, 1'b0);
    reg_wr(`MMC_OFS_INT_STAT, 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v, hi;
    logic [15:0] d;
    logic [4:0] p, r;
    logic [3:0] sd;
    int k, n;
    k = $urandom(32'h4FD0);
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    // reset values, then one unmapped address
    for (k = 8'h3B; k < 8'h45; k++) begin
      reg_rd(k[7:0], v);
      check(16'(v), 16'h0000);
    end
    // clock enable low freezes the divider and drops register writes
    @(posedge mclk);
    ce <= 1'b0;
    @(posedge mclk);
    n = int'(mdc);
    reg_wr(`MMC_OFS_PHY_ADDR, 8'h15);
    repeat (20) @(posedge mclk);
    check(16'(mdc), 16'(n));
    ce <= 1'b1;
    reg_rd(`MMC_OFS_PHY_ADDR, v);
    check(16'(v), 16'h0000);
    reg_wr(`MMC_OFS_CONTROL, 8'h2F);
    repeat (200) @(posedge mclk);
    reg_rd(`MMC_OFS_CONTROL, v);
    check(16'(v), 16'h002F);
    check(16'(f_count), 16'h0000);
    $display("test registers done");
    // eight writes over all divisor codes, then four reads
    for (k = 0; k < 12; k++) begin
      sd = {1'($urandom), (k < 8) ? k[2:0] : 3'($urandom)};
      d = 16'($urandom);
      p = 5'($urandom);
      r = 5'($urandom);
      reply_base = d;
      n = f_count;
      reg_wr(`MMC_OFS_WDATA_LO, d[7:0]);
      reg_wr(`MMC_OFS_WDATA_HI, d[15:8]);
      reg_wr(`MMC_OFS_PHY_ADDR, {3'h0, p});
      reg_wr(`MMC_OFS_REG_SEL, {3'h0, r});
      reg_wr(`MMC_OFS_CONTROL, {k < 8, k >= 8, 2'h0, sd});
      reg_rd(`MMC_OFS_STATUS, v);
      check(16'(v[7]), 16'h0001);
      reg_wr(`MMC_OFS_CONTROL, {k >= 8, k < 8, 2'h0, sd});
      wait_bit(`MMC_OFS_INT_STAT, 0, 1'b1);
      reg_wr(`MMC_OFS_INT_STAT, 8'h01);
      reg_rd(`MMC_OFS_INT_STAT, v);
      check(16'(v), 16'h0000);
      repeat (120) @(posedge mclk);
      reg_rd(`MMC_OFS_STATUS, v);
      check(16'(v), 16'(p));
      reg_rd(`MMC_OFS_CONTROL, v);
      check(16'(v), 16'(sd));
      check(16'(f_count - n), 16'h0001);
      check({2'h0, f_op, f_phy, f_reg, f_ta}, {2'h0, k < 8 ? 2'h1 : 2'h2, p, r, 2'h2});
      check(16'(f_pre), sd[3] ? 16'h0000 : 16'h0020);
      check(16'(period), 16'(div_of(sd[2:0])));
      check(f_data, (k < 8) ? d : d ^ 16'(p));
      check(16'(f_clash), 16'h0000);
      reg_rd(`MMC_OFS_RDATA_LO, v);
      reg_rd(`MMC_OFS_RDATA_HI, hi);
      if (k >= 8) check({hi, v}, d ^ 16'(p));
    end
    $display("test single frames done");
    scan_run(5'($urandom), 1'b0);
    scan_run(5'h1D, 1'b1);
    $display("test scan done");
    end_of_test;
  end
endmodule
